// ### verilog/bus48_fault_defs.svh
`ifndef BUS48_FAULT_DEFS_SVH
`define BUS48_FAULT_DEFS_SVH

`define RESP_CTRL_ADDR     8'hB8
`define FAULT_STATUS_ADDR  8'hD7
`define RESP_CTRL_RESET    8'h00
`define FAULT_STATUS_RESET 8'h00
`define NUM_FAULTS         4
`define STATUS_BIT_BASE    4
`define CODE_W             2
`define CLK_FREQ_HZ        100000000
`define HICCUP_DELAY_MS    500
`define MS_TICK_CYCLES     (`CLK_FREQ_HZ / 1000)
`define TICK_CNT_W         17
`define HICCUP_CNT_W       10

`endif

// ### verilog/bus48_fault_pkg.sv
package bus48_fault_pkg;

  typedef enum logic [1:0] {
    RESP_FLAG     = 2'h0,
    RESP_HICCUP   = 2'h1,
    RESP_LATCH    = 2'h2,
    RESP_FLAG_ALT = 2'h3
  } resp_code_t;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_HOLD  = 4'h2,
    ST_WAIT  = 4'h4,
    ST_LATCH = 4'h8
  } unit_state_t;

endpackage : bus48_fault_pkg

// ### verilog/fault_lane_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fault_lane_if;
  import bus48_fault_pkg::*;
  logic       fault_det;
  resp_code_t code;
  logic       ms_tick;
  logic       restart;
  logic       inhibit;

  modport unit (input fault_det, code, ms_tick, restart, output inhibit);
  modport ctrl (output fault_det, code, ms_tick, restart, input inhibit);
endinterface : fault_lane_if
`default_nettype wire

// ### verilog/fault_response_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "bus48_fault_defs.svh"
module fault_response_unit
  import bus48_fault_pkg::*;
#(
  parameter int HICCUP_MS = `HICCUP_DELAY_MS,
  parameter int CNT_W     = `HICCUP_CNT_W
) (
  input  wire logic  core_clk,  // System clock
  input  wire logic  rst,       // Synchronous reset, high
  fault_lane_if.unit lane       // One fault lane
);

  unit_state_t      state_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (lane.fault_det && lane.code == RESP_HICCUP) begin
            state_q <= ST_HOLD;
          end else if (lane.fault_det && lane.code == RESP_LATCH) begin
            state_q <= ST_LATCH;
          end
        end
        ST_HOLD: begin
          if (!lane.fault_det) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (lane.fault_det) begin
            state_q <= ST_HOLD;
          end else if (cnt_q == CNT_W'(HICCUP_MS)) begin
            state_q <= ST_RUN;
          end
        end
        ST_LATCH: begin
          // Only an enable toggle frees it; a clear fault is not enough
          if (lane.restart && !lane.fault_det) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Counts ms ticks since the fault cleared
  always_ff @(posedge core_clk) begin
    if (rst || state_q != ST_WAIT) begin
      cnt_q <= '0;
    end else if (lane.ms_tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Codes 00 and 11 never leave ST_RUN, so switching keeps going
  assign lane.inhibit = (state_q != ST_RUN);

endmodule : fault_response_unit
`default_nettype wire

// ### verilog/bus48_fault_response_control.sv
// How it works
// - Eight-bit read/write response control register, reset to zero.
// - Bits 1:0 pick output overvoltage response; fault sets status bit 4.
// - Bits 3:2 pick output undervoltage response; fault sets status bit 5.
// - Bits 5:4 pick input overvoltage response; fault sets status bit 6.
// - Bits 7:6 pick input undervoltage response; fault sets status bit 7.
// - Fields apply only when global enable is one; else mode pin code.
// - Code 00 flags the fault and keeps switching.
// - Code 11 behaves the same as code 00.
// - Fault pin pulled low whenever any protection fault is detected.
// - Code 01 stops switching, restarts 500 ms after fault clears.
// - Code 10 stops switching until an enable is toggled while the fault is clear.
`timescale 1ns/100ps
`default_nettype none
`include "bus48_fault_defs.svh"
module bus48_fault_response_control
  import bus48_fault_pkg::*;
#(
  parameter int MS_TICK_CYCLES = `MS_TICK_CYCLES,
  parameter int HICCUP_MS      = `HICCUP_DELAY_MS
) (
  input  wire logic       core_clk,             // System clock
  input  wire logic       rst,                  // Synchronous reset, high
  input  wire logic       reg_wr_en,            // Register write strobe
  input  wire logic       reg_rd_en,            // Register read strobe
  input  wire logic [7:0] reg_addr,             // Register address
  input  wire logic [7:0] reg_wr_data,          // Write data
  output logic      [7:0] reg_rd_data,          // Read data
  output logic            reg_rd_valid,         // Read data valid
  input  wire logic       indiv_resp_en,        // Global per-fault enable
  input  wire logic [1:0] mode_resp_code,       // Response from mode pin
  input  wire logic       pwm_en,               // Switching enable
  input  wire logic       main_en,              // Main enable
  input  wire logic [3:0] fault_det,            // Protection comparators
  output logic            switching_inhibit,    // Stop PWM switching
  output logic            fault_status_pin_n_o, // Fault pin drive value
  output logic            fault_status_pin_n_oe // Fault pin drive enable
);

  localparam int NF = `NUM_FAULTS;
  localparam int CW = `CODE_W;
  // Only the high nibble of the status byte lives here
  localparam logic [7:0] STATUS_RST = `FAULT_STATUS_RESET;

  logic [7:0]             resp_ctrl_q;
  logic [NF-1:0]          status_q;
  logic [`TICK_CNT_W-1:0] tick_cnt_q;
  logic                   ms_tick;
  logic                   pwm_en_q;
  logic                   main_en_q;
  logic                   restart;
  logic                   pin_low_q;
  logic [NF-1:0]          inhibit;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_ctrl_q <= `RESP_CTRL_RESET;
    end else if (reg_wr_en && hit(reg_addr, `RESP_CTRL_ADDR)) begin
      resp_ctrl_q <= reg_wr_data;
    end
  end

  // Sticky fault status; write one to clear, a new fault wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_q <= STATUS_RST[`STATUS_BIT_BASE +: NF];
    end else begin
      for (int i = 0; i < NF; i++) begin
        if (fault_det[i]) begin
          status_q[i] <= 1'b1;
        end else if (reg_wr_en && hit(reg_addr, `FAULT_STATUS_ADDR) &&
                     reg_wr_data[`STATUS_BIT_BASE + i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (!reg_rd_en) begin
        reg_rd_data <= 8'h00;
      end else if (hit(reg_addr, `RESP_CTRL_ADDR)) begin
        reg_rd_data <= resp_ctrl_q;
      end else if (hit(reg_addr, `FAULT_STATUS_ADDR)) begin
        // Low nibble belongs to the low-voltage bus, not this block
        reg_rd_data <= {status_q, 4'h0};
      end else begin
        reg_rd_data <= 8'h00;
      end
    end
  end

  // Shared ms divider: hiccup delay carries up to one tick of jitter
  always_ff @(posedge core_clk) begin
    if (rst || tick_cnt_q == `TICK_CNT_W'(MS_TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + `TICK_CNT_W'(1);
    end
  end
  assign ms_tick = (tick_cnt_q == `TICK_CNT_W'(MS_TICK_CYCLES - 1));

  // Any edge of either enable counts as a toggle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwm_en_q  <= 1'b0;
      main_en_q <= 1'b0;
    end else begin
      pwm_en_q  <= pwm_en;
      main_en_q <= main_en;
    end
  end
  assign restart = (pwm_en ^ pwm_en_q) | (main_en ^ main_en_q);

  fault_lane_if lane [NF] ();

  for (genvar g = 0; g < NF; g++) begin : g_lane
    assign lane[g].fault_det = fault_det[g];
    // Mode pin code overrides the field while per-fault mode is off
    assign lane[g].code = resp_code_t'(indiv_resp_en ?
                          resp_ctrl_q[g*CW +: CW] :
                          mode_resp_code);
    assign lane[g].ms_tick = ms_tick;
    assign lane[g].restart = restart;
    assign inhibit[g] = lane[g].inhibit;

    fault_response_unit #(
      .HICCUP_MS (HICCUP_MS),
      .CNT_W     (`HICCUP_CNT_W)
    ) u_unit (
      .core_clk (core_clk),
      .rst      (rst),
      .lane     (lane[g])
    );
  end

  assign switching_inhibit = |inhibit;

  // Open drain: only ever pulls low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= |fault_det;
    end
  end
  assign fault_status_pin_n_o  = 1'b0;
  assign fault_status_pin_n_oe = pin_low_q;

endmodule : bus48_fault_response_control
`default_nettype wire

// ### testbench/bus48_fault_response_control_chk.sv
`timescale 1ns/100ps
`default_nettype none
module bus48_fault_chk (
  input wire logic       core_clk,              // Clock
  input wire logic       rst,                   // Reset
  input wire logic       reg_wr_en,             // Write
  input wire logic       reg_rd_en,             // Read
  input wire logic [7:0] reg_addr,              // Address
  input wire logic [7:0] reg_wr_data,           // Write data
  input wire logic [7:0] reg_rd_data,           // Read data
  input wire logic       reg_rd_valid,          // Read valid
  input wire logic       indiv_resp_en,         // Field enable
  input wire logic [1:0] mode_resp_code,        // Pin code
  input wire logic       pwm_en,                // Enable
  input wire logic       main_en,               // Enable
  input wire logic [3:0] fault_det,             // Faults
  input wire logic       switching_inhibit,     // Inhibit
  input wire logic       fault_status_pin_n_o,  // Pin value
  input wire logic       fault_status_pin_n_oe  // Pin enable
);
  logic [7:0] ctrl_q;
  logic [3:0] stop_lane;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk) begin
    if (rst) ctrl_q <= 8'h00;
    else if (reg_wr_en && reg_addr == 8'hB8) ctrl_q <= reg_wr_data;
  end
  // Faulted lanes whose field asks to stop (codes 01, 10)
  assign stop_lane = fault_det & {^ctrl_q[7:6], ^ctrl_q[5:4],
                                  ^ctrl_q[3:2], ^ctrl_q[1:0]};
  property p_rd_valid; reg_rd_en |=> reg_rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("no read valid");
  property p_wr_rd; reg_wr_en && reg_addr == 8'hB8 ##1 reg_rd_en &&
    reg_addr == 8'hB8 |=> reg_rd_data == $past(reg_wr_data, 2); endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("control readback wrong");
  property p_unmapped; reg_rd_en && reg_addr != 8'hB8 && reg_addr != 8'hD7
    |=> reg_rd_data == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_status; fault_det != 4'h0 ##1 reg_rd_en && reg_addr == 8'hD7
    |=> (reg_rd_data[7:4] & $past(fault_det, 2)) == $past(fault_det, 2);
  endproperty
  a_status: assert property (p_status)
    else $error("status bit not set");
  property p_oe_on; fault_det != 4'h0 |=> fault_status_pin_n_oe; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("pin not pulled");
  property p_oe_off; fault_det == 4'h0 |=> !fault_status_pin_n_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("pin pulled without fault");
  property p_pin_low; fault_status_pin_n_oe |-> !fault_status_pin_n_o;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("pin driven high");
  // Only from a running state: held lanes may still be counting down
  property p_flag; !switching_inhibit && (indiv_resp_en ? stop_lane == 4'h0
    : (!(^mode_resp_code) || fault_det == 4'h0)) |=> !switching_inhibit;
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag code stopped switching");
  property p_stop; (indiv_resp_en ? stop_lane != 4'h0
    : (^mode_resp_code && fault_det != 4'h0)) |=> switching_inhibit;
  endproperty
  a_stop: assert property (p_stop)
    else $error("switching not stopped");
endmodule : bus48_fault_chk
bind bus48_fault_response_control bus48_fault_chk u_chk (.*);
`default_nettype wire

// ### testbench/test_bus48_fault_response_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_bus48_fault_response_control;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr_en = 1'b0;
  logic       reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_rd_data;
  logic       reg_rd_valid;
  logic       indiv_resp_en = 1'b1;
  logic [1:0] mode_resp_code = 2'h0;
  logic       pwm_en = 1'b0;
  logic       main_en = 1'b0;
  logic [3:0] fault_det = 4'h0;
  logic       switching_inhibit;
  logic       fault_status_pin_n_o;
  logic       fault_status_pin_n_oe;
  int         err_count = 0;
  int         checked = 0;
  int         cycles = 0;
  // Short tick so the hiccup wait is 12 cycles
  bus48_fault_response_control #(.MS_TICK_CYCLES(4), .HICCUP_MS(3)) uut (.*);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk_bit(input logic got, input logic exp, input string s);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %b", $time, s, got);
    end
  endtask : chk_bit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    tick(1);
    reg_wr_en = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd_en = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd_en = 1'b0;
    checked++;
    if (reg_rd_valid !== 1'b1 || reg_rd_data !== exp) begin
      err_count++;
      $display("MISMATCH %0t read %h got %h", $time, a, reg_rd_data);
    end
    tick(1);
  endtask : rd
  // Read straight after the write, with no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    tick(1);
    reg_wr_en = 1'b0;
    rd(a, d);
  endtask : wr_rd
  initial begin
    tick(12);
    rst = 1'b0;
    rd(8'hB8, 8'h00);
    wr(8'hB8, 8'hA5);
    rd(8'hB8, 8'hA5);
    wr_rd(8'hB8, 8'h3C);
    rd(8'hB0, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wr(8'hB8, j ? 8'hFF : 8'h00);
      fault_det = 4'hF;
      tick(2);
      chk_bit(switching_inhibit, 1'b0, "flag");
      chk_bit(fault_status_pin_n_oe, 1'b1, "pin");
      chk_bit(fault_status_pin_n_o, 1'b0, "pin level");
      fault_det = 4'h0;
      tick(2);
      chk_bit(fault_status_pin_n_oe, 1'b0, "pin free");
    end
    wr(8'hD7, 8'hF0);
    for (int i = 0; i < 4; i++) begin
      wr(8'hB8, 8'h02 << (2 * i));
      fault_det[i] = 1'b1;
      tick(1);
      chk_bit(switching_inhibit, 1'b1, "latch");
      fault_det[i] = 1'b0;
      rd(8'hD7, 8'h10 << i);
      tick(3);
      chk_bit(switching_inhibit, 1'b1, "latch hold");
      if (i[0]) main_en = ~main_en;
      else pwm_en = ~pwm_en;
      tick(2);
      chk_bit(switching_inhibit, 1'b0, "restart");
      wr(8'hD7, 8'hF0);
    end
    indiv_resp_en = 1'b0;
    wr(8'hB8, 8'h55);
    fault_det = 4'h4;
    tick(2);
    chk_bit(switching_inhibit, 1'b0, "fields ignored");
    fault_det = 4'h0;
    mode_resp_code = 2'h1;
    tick(2);
    fault_det = 4'h4;
    tick(5);
    chk_bit(switching_inhibit, 1'b1, "hiccup");
    fault_det = 4'h0;
    tick(6);
    chk_bit(switching_inhibit, 1'b1, "hiccup wait");
    tick(9);
    chk_bit(switching_inhibit, 1'b0, "hiccup end");
    end_sim();
  end
endmodule : test_bus48_fault_response_control
`default_nettype wire
